// ### rtl/sss_pkg.sv
/*
  startup strap mode sequencer package: states, strap result carrier,
  register offsets, field positions, reset values and timing counts.
  assumes a single 250 mhz clock (mclk) in every user of the package.
*/
package sss_pkg;

  // ***********************************************************
  // clock and timing
  // ***********************************************************
  localparam int unsigned CLK_PERIOD_NS = 4;
  // settle time on the straps inside initialisation mode
  localparam int unsigned INIT_DETECT_NS = 1000;
  // restart_active_time, in microseconds
  localparam int unsigned RESTART_ACTIVE_US = 2;
  // least times round up to whole cycles
  localparam int unsigned INIT_DETECT_CYC =
    (INIT_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESTART_ACTIVE_CYC =
    (RESTART_ACTIVE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 12;

  // ***********************************************************
  // sequencer states
  // ***********************************************************
  typedef enum logic [2:0] {
    SEQ_POR,
    SEQ_DIG_INIT,
    SEQ_REG_RAMP,
    SEQ_INIT,
    SEQ_RESTART,
    SEQ_STANDBY
  } sss_state_t;

  // ***********************************************************
  // latched strap results
  // ***********************************************************
  typedef struct packed {
    logic valid;       // straps have been sampled
    logic serial_ctrl; // 1: serial-port control, 0: pin control
    logic io_5v;       // serial signalling at 5 v (high variant only)
    logic wake_out;    // 1: wake_request_output, 0: inhibit output
  } sss_strap_t;

  localparam sss_strap_t STRAP_RST = '{default: 1'b0};

  // ***********************************************************
  // register map (byte addresses)
  // ***********************************************************
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h4;
  // status fields
  localparam int unsigned ST_STATE_LSB = 0;
  localparam int unsigned ST_VALID_BIT = 4;
  localparam int unsigned ST_SERIAL_BIT = 5;
  localparam int unsigned ST_IO5V_BIT = 6;
  localparam int unsigned ST_WAKE_BIT = 7;
  localparam int unsigned ST_BROWN_BIT = 8;
  // control fields
  localparam int unsigned CT_HOLD_BIT = 0;
  localparam logic CT_HOLD_RST = 1'b0;

  // ***********************************************************
  // synchronised pin inputs
  // ***********************************************************
  localparam int unsigned N_PINS = 7;

endpackage : sss_pkg

// ### rtl/sss_sync.sv
/*
  two flip-flop synchroniser for a vector of level inputs.
  assumes the inputs are quasi-static comparator and strap levels.
*/
`timescale 1ns/100ps
`default_nettype none

module sss_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // levels
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // first stage is read only by the second stage
  logic [W-1:0] meta_q;

  // ***********************************************************
  // two-stage capture
  // ***********************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // sss_sync

`default_nettype wire

// ### rtl/sss_seq.sv
/*
  startup strap mode sequencer: steps from power-on reset through
  digital release and regulator ramp into initialisation mode, samples
  the control-select and wake/inhibit straps, then goes through restart
  into standby. an avalon-mm slave shows state and strap results.
  assumes analog comparator flags and strap detectors arrive
  asynchronously and rst_n is the power-on reset.
*/
// Summary of operation
// - control mode fixed until next power-on reset or brownout
// - strap at ground selects pin control
// - strap floating or high selects serial control
// - high variant: float 3.3 v, pulled-up 5 v
// - 100k pull-down gives wake output, else inhibit
// - wake/inhibit detection done inside initialisation mode
// - por comparator releases digital logic and clocks
// - supply ok starts ramp; regulator ok enters init
// - init exit follows the sampled control strap
// - brownout restarts the whole power-up sequence
// - restart mode lasts restart time, then standby
`timescale 1ns/100ps
`default_nettype none

module sss_seq
  import sss_pkg::*;
(
  // clock and power-on reset
  input wire logic mclk,
  input wire logic rst_n,
  // analog comparator flags
  input wire logic por_rising_ok,
  input wire logic supply_uv_ok,
  input wire logic regulator_uv_ok,
  // strap detectors and variant select
  input wire logic ctrl_strap_low,
  input wire logic ctrl_strap_high,
  input wire logic wake_pulldown_det,
  input wire logic high_variant,
  // sequencer outputs
  output logic digital_release_q,
  output logic ldo_enable_q,
  output logic init_mode_q,
  output logic restart_mode_q,
  output logic standby_mode_q,
  output logic pin_ctrl_en_q,
  output logic serial_ctrl_en_q,
  output logic io_5v_q,
  output logic wake_request_output_q,
  output logic high_voltage_inhibit_output_q,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);

  // ***********************************************************
  // input synchronisation
  // ***********************************************************
  logic [N_PINS-1:0] pins_raw; // asynchronous levels
  logic [N_PINS-1:0] pins_s; // synchronised levels
  assign pins_raw = {high_variant, wake_pulldown_det, ctrl_strap_high,
                     ctrl_strap_low, regulator_uv_ok, supply_uv_ok,
                     por_rising_ok};

  sss_sync #(.W(N_PINS)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  wire por_ok = pins_s[0];
  wire sup_ok = pins_s[1];
  wire reg_ok = pins_s[2];
  wire strap_lo = pins_s[3];
  wire strap_hi = pins_s[4];
  wire wake_pd = pins_s[5];
  wire hv_var = pins_s[6];

  // ***********************************************************
  // state and counters
  // ***********************************************************
  sss_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d; // dwell counter in init and restart
  sss_strap_t strap_q, strap_d; // latched strap results
  logic brownout_seen_q, brownout_seen_d; // sticky, cleared on read
  logic hold_q, hold_d; // software hold in restart mode

  // dwell limits
  localparam logic [CNT_W-1:0] DETECT_LAST = CNT_W'(INIT_DETECT_CYC - 1);
  localparam logic [CNT_W-1:0] RESTART_LAST =
    CNT_W'(RESTART_ACTIVE_CYC - 1);

  // brownout: supply fell below its falling threshold after start
  wire brownout = !sup_ok && (state_q != SEQ_POR)
                  && (state_q != SEQ_DIG_INIT);
  wire detect_done = (state_q == SEQ_INIT) && (cnt_q == DETECT_LAST);
  wire restart_done = (state_q == SEQ_RESTART) && (cnt_q >= RESTART_LAST)
                      && !hold_q;

  // strap decode, valid only at the sampling moment
  wire samp_serial = !strap_lo;
  wire samp_5v = samp_serial && hv_var && strap_hi;
  wire samp_wake = wake_pd;

  // ***********************************************************
  // next-state logic
  // ***********************************************************
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    strap_d = strap_q;
    unique case (state_q)
      SEQ_POR: begin
        // digital logic and clocks released by the por comparator
        if (por_ok) begin
          state_d = SEQ_DIG_INIT;
        end
      end
      SEQ_DIG_INIT: begin
        // wait for the supply to clear its rising undervoltage level
        if (!por_ok) begin
          state_d = SEQ_POR;
        end else if (sup_ok) begin
          state_d = SEQ_REG_RAMP;
        end
      end
      SEQ_REG_RAMP: begin
        // ldo ramps until the regulator comparator reports ok
        if (reg_ok) begin
          state_d = SEQ_INIT;
          cnt_d = '0;
        end
      end
      SEQ_INIT: begin
        cnt_d = cnt_q + 1'b1;
        if (detect_done) begin
          // sample once, before leaving init
          if (!strap_q.valid) begin
            strap_d = '{valid: 1'b1, serial_ctrl: samp_serial,
                        io_5v: samp_5v, wake_out: samp_wake};
          end
          state_d = SEQ_RESTART;
          cnt_d = '0;
        end
      end
      SEQ_RESTART: begin
        if (cnt_q < RESTART_LAST) begin
          cnt_d = cnt_q + 1'b1;
        end
        if (restart_done) begin
          state_d = SEQ_STANDBY;
        end
      end
      SEQ_STANDBY: begin
        // later modes are handled elsewhere
        state_d = SEQ_STANDBY;
      end
    endcase
    // brownout overrides every state past digital init and forgets the straps
    if (brownout) begin
      state_d = SEQ_POR;
      cnt_d = '0;
      strap_d = STRAP_RST;
    end
  end

  // ***********************************************************
  // register file, avalon-mm slave
  // ***********************************************************
  wire bus_req = avs_read || avs_write;
  wire bus_take = bus_req && !avs_waitrequest; // the completing edge
  wire sel_status = (avs_address == REG_STATUS);
  wire sel_control = (avs_address == REG_CONTROL);
  wire ctl_wr = avs_write && bus_take && sel_control;
  wire st_rd = avs_read && bus_take && sel_status;

  logic [31:0] status_word;
  logic [31:0] rdata_d;
  always_comb begin
    status_word = '0;
    status_word[ST_STATE_LSB +: 3] = state_q;
    status_word[ST_VALID_BIT] = strap_q.valid;
    status_word[ST_SERIAL_BIT] = strap_q.serial_ctrl;
    status_word[ST_IO5V_BIT] = strap_q.io_5v;
    status_word[ST_WAKE_BIT] = strap_q.wake_out;
    status_word[ST_BROWN_BIT] = brownout_seen_q;
    rdata_d = '0; // unmapped addresses read as zero
    if (sel_status) begin
      rdata_d = status_word;
    end else if (sel_control) begin
      rdata_d[CT_HOLD_BIT] = hold_q;
    end
  end

  // hold bit keeps the block in restart mode for software inspection
  assign hold_d = ctl_wr ? avs_writedata[CT_HOLD_BIT] : hold_q;
  // a new brownout wins over a clearing read
  assign brownout_seen_d = brownout || (brownout_seen_q && !st_rd);

  // ***********************************************************
  // state registers
  // ***********************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= SEQ_POR;
      cnt_q <= '0;
      strap_q <= STRAP_RST;
      brownout_seen_q <= 1'b0;
      hold_q <= CT_HOLD_RST;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      strap_q <= strap_d;
      brownout_seen_q <= brownout_seen_d;
      hold_q <= hold_d;
    end
  end

  // bus answer: one wait cycle, then a single low waitrequest cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= '0;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
      if (bus_req && avs_waitrequest) begin
        avs_readdata <= rdata_d;
      end
    end
  end

  // ***********************************************************
  // registered outputs
  // ***********************************************************
  wire in_run = (state_q == SEQ_RESTART) || (state_q == SEQ_STANDBY);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      digital_release_q <= 1'b0;
      ldo_enable_q <= 1'b0;
      init_mode_q <= 1'b0;
      restart_mode_q <= 1'b0;
      standby_mode_q <= 1'b0;
      pin_ctrl_en_q <= 1'b0;
      serial_ctrl_en_q <= 1'b0;
      io_5v_q <= 1'b0;
      wake_request_output_q <= 1'b0;
      high_voltage_inhibit_output_q <= 1'b0;
    end else begin
      digital_release_q <= (state_q != SEQ_POR);
      ldo_enable_q <= (state_q != SEQ_POR)
                      && (state_q != SEQ_DIG_INIT);
      init_mode_q <= (state_q == SEQ_INIT);
      restart_mode_q <= (state_q == SEQ_RESTART);
      standby_mode_q <= (state_q == SEQ_STANDBY);
      // exit flow chosen by the latched control strap
      pin_ctrl_en_q <= in_run && !strap_q.serial_ctrl;
      serial_ctrl_en_q <= in_run && strap_q.serial_ctrl;
      io_5v_q <= in_run && strap_q.io_5v;
      wake_request_output_q <= in_run && strap_q.wake_out;
      high_voltage_inhibit_output_q <= in_run
                                       && !strap_q.wake_out;
    end
  end

endmodule // sss_seq

`default_nettype wire

// ### verif/sss_chk.sv
/* sss_chk: assertions on the sss_seq ports.
   assumes one mclk domain; bound to every sss_seq. */
`timescale 1ns/100ps
`default_nettype none
module sss_chk
  import sss_pkg::*;
(
  // clock, reset, flags
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic por_rising_ok,
  input wire logic supply_uv_ok,
  input wire logic regulator_uv_ok,
  // sequencer outputs
  input wire logic digital_release_q,
  input wire logic ldo_enable_q,
  input wire logic init_mode_q,
  input wire logic restart_mode_q,
  input wire logic standby_mode_q,
  input wire logic pin_ctrl_en_q,
  input wire logic serial_ctrl_en_q,
  input wire logic io_5v_q,
  input wire logic wake_request_output_q,
  input wire logic high_voltage_inhibit_output_q
);
  // ******************************************
  // mode length counters
  // ******************************************
  logic [CNT_W-1:0] ini_q, ini_d, rs_q, rs_d;
  assign ini_d = init_mode_q ? ini_q + 1'b1 : '0;
  assign rs_d = restart_mode_q ? rs_q + 1'b1 : '0;
  // cycles spent in the current mode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ini_q <= '0;
      rs_q <= '0;
    end else begin
      ini_q <= ini_d;
      rs_q <= rs_d;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // flag held low long enough to flush the synchroniser
  sequence s_por_low; !por_rising_ok [*4]; endsequence
  sequence s_reg_low; !regulator_uv_ok [*4]; endsequence
  wire logic run_w = restart_mode_q || standby_mode_q;
  property p_por_gate; s_por_low |=> !$rose(digital_release_q); endproperty
  a_por_gate: assert property (p_por_gate)
    else $error("digital release without por flag");
  property p_ramp; $rose(ldo_enable_q) |-> $past(digital_release_q); endproperty
  a_ramp: assert property (p_ramp)
    else $error("ramp started before digital release");
  property p_reg_gate; s_reg_low |=> !$rose(init_mode_q); endproperty
  a_reg_gate: assert property (p_reg_gate)
    else $error("init entered without regulator flag");
  property p_init_len;
    $fell(init_mode_q) && restart_mode_q |-> ini_q == INIT_DETECT_CYC;
  endproperty
  a_init_len: assert property (p_init_len)
    else $error("init mode length wrong");
  property p_rs_len; $rose(standby_mode_q) |-> rs_q == RESTART_ACTIVE_CYC;
  endproperty
  a_rs_len: assert property (p_rs_len)
    else $error("restart mode length wrong");
  property p_one_ctrl; run_w |-> pin_ctrl_en_q ^ serial_ctrl_en_q; endproperty
  a_one_ctrl: assert property (p_one_ctrl)
    else $error("control mode not one-hot");
  property p_wake;
    run_w |-> wake_request_output_q ^ high_voltage_inhibit_output_q;
  endproperty
  a_wake: assert property (p_wake)
    else $error("wake/inhibit not one-hot");
  property p_io5v; io_5v_q |-> serial_ctrl_en_q; endproperty
  a_io5v: assert property (p_io5v)
    else $error("5 v level outside serial control");
  property p_latch;
    standby_mode_q && $past(standby_mode_q) |-> $stable({pin_ctrl_en_q,
      serial_ctrl_en_q, io_5v_q, wake_request_output_q});
  endproperty
  a_latch: assert property (p_latch)
    else $error("strap result changed in standby");
  property p_brown; $fell(supply_uv_ok) && standby_mode_q |->
    ##[1:6] !run_w && !pin_ctrl_en_q && !serial_ctrl_en_q;
  endproperty
  a_brown: assert property (p_brown)
    else $error("brownout did not restart sequence");
endmodule // sss_chk
bind sss_seq sss_chk chk_u (.mclk, .rst_n, .por_rising_ok, .supply_uv_ok,
  .regulator_uv_ok, .digital_release_q, .ldo_enable_q, .init_mode_q,
  .restart_mode_q, .standby_mode_q, .pin_ctrl_en_q, .serial_ctrl_en_q,
  .io_5v_q, .wake_request_output_q, .high_voltage_inhibit_output_q);
`default_nettype wire

// ### verif/sss_env.sv
/* sss_env: supply, regulator and strap model around sss_seq.
   assumes the bench drives its commands at mclk edges. */
`timescale 1ns/100ps
`default_nettype none
module sss_env #(
  parameter int RAMP_CYC = 20
) (
  // commands from the bench, and ldo enable from sss_seq
  input wire logic mclk,
  input wire logic bat_on,
  input wire logic sup_on,
  input wire logic [1:0] strap_sel,
  input wire logic wake_pd,
  input wire logic ldo_enable_q,
  // analog flags and strap detectors
  output logic por_rising_ok,
  output logic supply_uv_ok,
  output logic regulator_uv_ok,
  output logic ctrl_strap_low,
  output logic ctrl_strap_high,
  output logic wake_pulldown_det
);
  int ramp = 0;
  // regulator only ramps while enabled and supplied
  always @(posedge mclk) begin
    ramp <= (ldo_enable_q && sup_on) ? ramp + 1 : 0;
  end
  assign por_rising_ok = bat_on;
  assign supply_uv_ok = bat_on && sup_on;
  assign regulator_uv_ok = ramp >= RAMP_CYC;
  // strap: 0 ground, 1 floating, 2 pulled up
  assign ctrl_strap_low = strap_sel == 2'd0;
  assign ctrl_strap_high = strap_sel == 2'd2;
  assign wake_pulldown_det = wake_pd;
endmodule // sss_env
`default_nettype wire

// ### verif/sss_seq_test.sv
/* sss_seq_test: bench for sss_seq with the sss_env model.
   assumes a 250 mhz mclk and the registers of sss_pkg. */
`timescale 1ns/100ps
`default_nettype none
module sss_seq_test
  import sss_pkg::*;
;
  logic mclk = 1'b0, rst_n = 1'b0, bat_on = 1'b0, sup_on = 1'b0;
  logic wake_pd = 1'b0, high_variant = 1'b0, avs_read = 1'b0;
  logic avs_write = 1'b0, avs_waitrequest;
  logic [1:0] strap_sel = 2'd0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, d;
  logic por, sup, rok, slo, shi, wk, dr, ldo, ini, rs, sb, pc, sc, v5, wq, ih;
  int n_fail = 0, checked = 0, cyc = 0;
  always #2 mclk = ~mclk;
  sss_env env_u (.mclk, .bat_on, .sup_on, .strap_sel, .wake_pd,
    .ldo_enable_q(ldo), .por_rising_ok(por), .supply_uv_ok(sup),
    .regulator_uv_ok(rok), .ctrl_strap_low(slo), .ctrl_strap_high(shi),
    .wake_pulldown_det(wk));
  sss_seq dut_u (.mclk, .rst_n, .por_rising_ok(por), .supply_uv_ok(sup),
    .regulator_uv_ok(rok), .ctrl_strap_low(slo), .ctrl_strap_high(shi),
    .wake_pulldown_det(wk), .high_variant, .digital_release_q(dr),
    .ldo_enable_q(ldo), .init_mode_q(ini), .restart_mode_q(rs),
    .standby_mode_q(sb), .pin_ctrl_en_q(pc), .serial_ctrl_en_q(sc),
    .io_5v_q(v5), .wake_request_output_q(wq),
    .high_voltage_inhibit_output_q(ih), .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest);
  task report_and_stop;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      report_and_stop;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one bus transfer, held until waitrequest is sampled low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] w);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= w;
    avs_read <= !wr;
    avs_write <= wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge mclk);
  endtask
  task wait_st(input logic [2:0] s);
    for (int n = 0; n < 400; n++) begin
      bus(1'b0, REG_STATUS, 32'h0);
      if (d[2:0] === s) break;
    end
  endtask
  function logic [31:0] exp_pins(input int s, input logic w, input logic h);
    return {27'h0, s == 0, s != 0, s == 2 && h, w, !w};
  endfunction
  function logic [31:0] exp_st(input int s, input logic w, input logic h);
    return 32'h15 | {24'h0, w, s == 2 && h, s != 0, 5'h0};
  endfunction
  wire logic [31:0] pins_w = {27'h0, pc, sc, v5, wq, ih};
  wire logic [31:0] all_w = {21'h0, dr, ldo, ini, rs, sb, pins_w[4:0],
    avs_waitrequest};
  int s;
  logic w, h;
  initial begin
    void'($urandom(22));
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    chk(all_w, 32'h1);
    bus(1'b0, REG_STATUS, 32'h0);
    chk(d, 32'h0);
    bus(1'b1, REG_CONTROL, 32'h1);
    bus(1'b1, 4'hc, 32'hffff_ffff);
    bus(1'b0, REG_CONTROL, 32'h0);
    chk(d, 32'h1);
    bus(1'b0, 4'h8, 32'h0);
    chk(d, 32'h0);
    bus(1'b1, REG_CONTROL, 32'h0);
    $display("test bus done");
    for (int i = 0; i < 8; i++) begin
      s = (i < 6) ? i % 3 : $urandom % 3;
      w = (i < 6) ? i[0] : $urandom;
      h = (i < 6) ? i / 3 : $urandom;
      strap_sel <= 2'(s);
      wake_pd <= w;
      high_variant <= h;
      if (i == 0) bat_on <= 1'b1;
      else sup_on <= 1'b0;
      repeat (10) @(posedge mclk);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(d, (i == 0) ? 32'h1 : 32'h101);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(d, 32'h1);
      sup_on <= 1'b1;
      wait_st(3'd3);
      chk(32'(ini && ldo), 32'h1);
      wait_st(3'd5);
      chk(pins_w, exp_pins(s, w, h));
      strap_sel <= 2'(2 - s);
      wake_pd <= !w;
      repeat (20) @(posedge mclk);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(d, exp_st(s, w, h));
      chk(pins_w, exp_pins(s, w, h));
      $display("test strap %0d done", i);
    end
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(all_w, 32'h1);
    $display("test reset done");
    report_and_stop;
  end
endmodule // sss_seq_test
`default_nettype wire
